// file: bench/spi_host_model.sv
// Host side of the link: serial clock, select and data in mode 1.
// Assumes an 8 ns system clock; half a link period is ten cycles.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    // ------
    // Link driver
    // ------
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // 160 ns period, well under the top rate
    task automatic half();
        repeat (10) @(posedge clk_in);
    endtask
    task automatic sel();
        half();
        cs_n_out <= 1'b0;
        half();
    endtask
    // Released data line flips so a stale level never looks valid
    task automatic desel();
        half();
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        half();
    endtask
    task automatic shift(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out <= 1'b1;
            mosi_out <= tx[i];
            half();
            rx[i] = miso_in;
            sclk_out <= 1'b0;
            half();
        end
    endtask
endmodule
`default_nettype wire

// file: bench/spi_reg_slave_sva.sv
// Port-level checker for the serial register slave.
// Assumes link pins change only on system clock edges.
`timescale 1ns/1ps
`default_nettype none
module spi_reg_slave_sva #(
    parameter logic [7:0] WRITABLE_MASK = 8'hFF
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic serial_clock_in,
    input wire logic chip_select_n_in,
    input wire logic mosi_in,
    input wire logic miso_out,
    input wire logic miso_oe_out,
    input wire logic [9:0] reg_rd_addr_out,
    input wire logic [9:0] reg_wr_addr_out,
    input wire logic [7:0] reg_wr_data_out,
    input wire logic [7:0] reg_wr_mask_out,
    input wire logic reg_wr_valid_out,
    input wire logic reg_wr_ready_in
);
    // ------
    // Frame tracking
    // ------
    logic sclk_q_r;
    logic dir_r;
    logic [8:0] cnt_r;
    // Raw pin, unsynchronised: this count leads the design's own
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_q_r <= 1'b0;
            cnt_r <= 9'h000;
            dir_r <= 1'b0;
        end else begin
            sclk_q_r <= serial_clock_in;
            if (chip_select_n_in) begin
                cnt_r <= 9'h000;
            end else if (sclk_q_r && !serial_clock_in) begin
                cnt_r <= cnt_r + 9'h001;
                if (cnt_r == 9'h000) begin
                    dir_r <= mosi_in;
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    oe_off_a: assert property (chip_select_n_in [*8] |-> !miso_oe_out)
        else $error("output enabled while idle");
    hdr_zero_a: assert property (!chip_select_n_in && cnt_r != 9'h000 &&
        (dir_r || cnt_r < 9'h010) |-> !miso_out)
        else $error("output high outside read data");
    rd_step_a: assert property (!dir_r && cnt_r > 9'h010 && $changed(reg_rd_addr_out) |->
        reg_rd_addr_out == $past(reg_rd_addr_out) + 10'h001)
        else $error("read address did not step by one");
    wr_time_a: assert property ($rose(cnt_r == 9'h018) && dir_r |->
        ##[1:12] reg_wr_valid_out)
        else $error("write not issued after bit 24");
    short_wr_a: assert property ($rose(chip_select_n_in) && dir_r && cnt_r < 9'h018 &&
        !reg_wr_valid_out |=> !reg_wr_valid_out [*8])
        else $error("short frame produced a write");
    wr_hold_a: assert property (reg_wr_valid_out && !reg_wr_ready_in |=>
        reg_wr_valid_out && $stable(reg_wr_addr_out) && $stable(reg_wr_data_out))
        else $error("pending write changed while stalled");
    wr_data_a: assert property (reg_wr_valid_out |->
        (reg_wr_data_out & ~WRITABLE_MASK) == 8'h00)
        else $error("write data outside writable bits");
    wr_mask_a: assert property (reg_wr_mask_out == WRITABLE_MASK)
        else $error("write mask wrong");
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Bench for the serial register slave, with host model and register store.
// Assumes the store answers reads combinationally and drains the write FIFO.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------
    // Harness
    // ------
    localparam logic [7:0] WMASK = 8'h3F;
    localparam logic [7:0] UMASK = 8'h7F;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, cs_n, mosi, miso, oe, miso_last, ready, ovf, wr_valid;
    logic [9:0] rd_addr, wr_addr;
    logic [7:0] rd_data, wr_data, wr_mask;
    logic [17:0] last_wr;
    logic [7:0] mem [1024];
    int wr_cnt = 0;
    int miscompares = 0;
    int n_tests = 0;
    wire logic miso_w = oe ? miso : ~miso_last;
    always #4 clk = ~clk;
    assign rd_data = mem[rd_addr];
    always @(posedge clk) begin
        if (oe === 1'b1) begin
            miso_last <= miso;
        end
        if (wr_valid === 1'b1 && ready) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
            last_wr <= {wr_addr, wr_data};
            wr_cnt <= wr_cnt + 1;
        end
    end
    spi_host_model host_u (.clk_in(clk), .miso_in(miso_w), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi));
    spi_register_access_slave #(.WRITABLE_MASK(WMASK), .USED_MASK(UMASK)) dut_u (
        .clk_sys_in(clk), .arst_n_in(arst_n), .serial_clock_in(sclk),
        .chip_select_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe),
        .reg_rd_addr_out(rd_addr), .reg_rd_data_in(rd_data), .reg_wr_addr_out(wr_addr),
        .reg_wr_data_out(wr_data), .reg_wr_mask_out(wr_mask), .reg_wr_valid_out(wr_valid),
        .reg_wr_ready_in(ready), .wr_overflow_out(ovf));
    function automatic logic [7:0] expw(input logic [9:0] a, input logic [7:0] d);
        return ((a[7:0] ^ 8'hC3) & ~WMASK) | (d & WMASK);
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_wr(input int n);
        for (int k = 0; k < 4000 && wr_cnt != n; k++) begin
            @(posedge clk);
        end
        if (wr_cnt != n) begin
            miscompares++;
            end_sim();
        end
    endtask
    // ------
    // Scenarios
    // ------
    task automatic chain_frame(input logic [9:0] base);
        logic [23:0] rx;
        host_u.sel();
        for (int p = 0; p < 9; p++) begin
            host_u.shift({~p[0], base + 10'(p), 5'h00, 8'h10 + 8'(p)}, 24, rx);
        end
        host_u.desel();
    endtask
    task automatic t_wr_rd();
        logic [23:0] rx;
        logic [9:0] a;
        a = 10'h3FE;
        host_u.sel();
        host_u.shift({1'b1, a, 5'h00, 8'h5A}, 24, rx);
        host_u.desel();
        wait_wr(1);
        check({6'h00, last_wr}, {6'h00, a, 8'h1A});
        check(24'(mem[a]), 24'(expw(a, 8'h5A)));
        host_u.sel();
        host_u.shift({1'b0, a, 5'h15, 8'hFF}, 24, rx);
        check(rx, {16'h0000, mem[a] & UMASK});
        // Runs across the top of the space into address zero
        for (int k = 0; k < 3; k++) begin
            a = a + 10'h001;
            host_u.shift(24'h0000A5, 8, rx);
            check(rx, {16'h0000, mem[a] & UMASK});
        end
        host_u.desel();
    endtask
    task automatic t_abort();
        logic [23:0] rx;
        int n0;
        n0 = wr_cnt;
        host_u.sel();
        host_u.shift({1'b1, 10'h050, 5'h00, 8'h33} >> 4, 20, rx);
        host_u.desel();
        host_u.sel();
        host_u.shift({1'b1, 10'h051, 5'h00, 8'h2C}, 24, rx);
        host_u.desel();
        wait_wr(n0 + 1);
        repeat (40) @(posedge clk);
        check(24'(wr_cnt - n0), 24'h000001);
        check({6'h00, last_wr}, {6'h00, 10'h051, 8'h2C});
    endtask
    task automatic t_chain();
        int n0;
        n0 = wr_cnt;
        @(posedge clk);
        ready <= 1'b0;
        chain_frame(10'h100);
        check(24'(wr_valid), 24'h000001);
        @(posedge clk);
        ready <= 1'b1;
        wait_wr(n0 + 8);
        repeat (60) @(posedge clk);
        check(24'(wr_cnt - n0), 24'h000008);
        for (int p = 0; p < 8; p++) begin
            check(24'(mem[10'h100 + 10'(p)]), 24'(expw(10'h100 + 10'(p), 8'h10 + 8'(p))));
        end
        check(24'(mem[10'h108]), 24'h0000CB);
    endtask
    task automatic t_fill();
        int n0;
        n0 = wr_cnt;
        @(posedge clk);
        ready <= 1'b0;
        chain_frame(10'h200);
        chain_frame(10'h220);
        check(24'(ovf), 24'h000000);
        chain_frame(10'h240);
        check(24'(ovf), 24'h000001);
        @(posedge clk);
        ready <= 1'b1;
        // FIFO plus the one pending write at the port
        wait_wr(n0 + 17);
        repeat (20) @(posedge clk);
        check(24'(wr_cnt - n0), 24'h000011);
        check(24'(wr_valid), 24'h000000);
    endtask
    initial begin
        miso_last = 1'b0;
        ready = 1'b1;
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'(i) ^ 8'hC3;
        end
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (16) @(posedge clk);
        t_wr_rd();
        t_abort();
        t_chain();
        t_fill();
        end_sim();
    end
endmodule
bind spi_register_access_slave spi_reg_slave_sva #(.WRITABLE_MASK(WRITABLE_MASK)) chk_u (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .serial_clock_in(serial_clock_in),
    .chip_select_n_in(chip_select_n_in), .mosi_in(mosi_in), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out), .reg_rd_addr_out(reg_rd_addr_out),
    .reg_wr_addr_out(reg_wr_addr_out), .reg_wr_data_out(reg_wr_data_out),
    .reg_wr_mask_out(reg_wr_mask_out), .reg_wr_valid_out(reg_wr_valid_out),
    .reg_wr_ready_in(reg_wr_ready_in));
`default_nettype wire

// file: rtl/spi_reg_slave_pkg.sv
// Types shared by the serial register-access slave.
// Assumes nothing of its surroundings.
package spi_reg_slave_pkg;
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_HEADER,
        FR_READ,
        FR_WRITE
    } frame_state_t;
endpackage

// file: rtl/spi_reg_slave_regs.svh
// Constants for the serial register-access slave: frame layout, sizes, link rates.
// Assumes inclusion by bare name from the design file.
`ifndef SPI_REG_SLAVE_REGS_SVH
`define SPI_REG_SLAVE_REGS_SVH

`define SRS_ADDR_W 10
`define SRS_DATA_W 8
`define SRS_REG_COUNT 1024
`define SRS_FRAME_BITS 24
`define SRS_HDR_BITS 16
`define SRS_ADDR_END 11
`define SRS_MAX_EXTRA_PACKETS 7
`define SRS_PACKET_BITS 24
`define SRS_LINK_MAX_HZ 25000000
`define SRS_LINK_TYP_HZ 12500000
`define SRS_SYS_HZ 125000000
`define SRS_FIFO_DEPTH 16

`endif

// file: rtl/spi_register_access_slave.sv
// Mode 1 serial slave giving a host access to a 1024 x 8 register space.
// Assumes the register storage sits outside: reads come back combinationally
// from reg_rd_data_in for reg_rd_addr_out, writes leave through a FIFO port.
`timescale 1ns/1ps
`default_nettype none
`include "spi_reg_slave_regs.svh"
module spi_register_access_slave #(
    parameter int ADDR_W = `SRS_ADDR_W,
    parameter int DATA_W = `SRS_DATA_W,
    parameter int FIFO_DEPTH = `SRS_FIFO_DEPTH,
    parameter logic [`SRS_DATA_W-1:0] WRITABLE_MASK = 8'hFF,
    parameter logic [`SRS_DATA_W-1:0] USED_MASK = 8'hFF
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic serial_clock_in,
    input wire logic chip_select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic [ADDR_W-1:0] reg_rd_addr_out,
    input wire logic [DATA_W-1:0] reg_rd_data_in,
    output logic [ADDR_W-1:0] reg_wr_addr_out,
    output logic [DATA_W-1:0] reg_wr_data_out,
    output logic [DATA_W-1:0] reg_wr_mask_out,
    output logic reg_wr_valid_out,
    input wire logic reg_wr_ready_in,
    output logic wr_overflow_out
);
    initial begin
        if (ADDR_W != `SRS_ADDR_W || DATA_W != `SRS_DATA_W || FIFO_DEPTH < 2) begin
            $error("spi_register_access_slave: unsupported parameters");
        end
    end

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Three stages per pin; a change counts once stages two and three agree
    logic [2:0] sclk_sync_r;
    logic [2:0] cs_sync_r;
    logic [2:0] mosi_sync_r;
    logic sclk_q_r;
    logic cs_n_q_r;
    logic mosi_q_r;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_r <= 3'h0;
            cs_sync_r <= 3'h7;
            mosi_sync_r <= 3'h0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[1:0], serial_clock_in};
            cs_sync_r <= {cs_sync_r[1:0], chip_select_n_in};
            mosi_sync_r <= {mosi_sync_r[1:0], mosi_in};
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q_r <= 1'b0;
            cs_n_q_r <= 1'b1;
            mosi_q_r <= 1'b0;
        end else begin
            if (sclk_sync_r[1] == sclk_sync_r[2]) begin
                sclk_q_r <= sclk_sync_r[2];
            end
            if (cs_sync_r[1] == cs_sync_r[2]) begin
                cs_n_q_r <= cs_sync_r[2];
            end
            if (mosi_sync_r[1] == mosi_sync_r[2]) begin
                mosi_q_r <= mosi_sync_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sclk_prev_r;
    logic sclk_fall;
    logic sclk_rise;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_q_r;
        end
    end
    // Mode 1: master shifts on rising edge, both sides sample on falling
    assign sclk_fall = sclk_prev_r && !sclk_q_r && !cs_n_q_r;
    assign sclk_rise = !sclk_prev_r && sclk_q_r && !cs_n_q_r;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    spi_reg_slave_pkg::frame_state_t state_r;
    logic [4:0] bit_cnt_r;
    logic [`SRS_HDR_BITS-1:0] hdr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [ADDR_W-1:0] addr_r;
    logic [3:0] packets_r;
    logic [DATA_W-1:0] tx_r;
    logic fifo_ready;
    logic push_r;
    logic [ADDR_W-1:0] push_addr_r;
    logic [DATA_W-1:0] push_data_r;
    logic [4:0] last_bit;
    logic chained_r;
    logic frame_end_wr;
    logic chain_more;

    assign last_bit = 5'(`SRS_FRAME_BITS - 1);
    // 24th falling edge of a write packet
    assign frame_end_wr = state_r == spi_reg_slave_pkg::FR_WRITE && sclk_fall &&
        bit_cnt_r == last_bit;
    assign chain_more = packets_r < 4'(`SRS_MAX_EXTRA_PACKETS);
    assign reg_rd_addr_out = addr_r;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= spi_reg_slave_pkg::FR_IDLE;
            bit_cnt_r <= 5'h00;
            hdr_r <= 16'h0000;
            addr_r <= 10'h000;
        end else begin
            if (cs_n_q_r) begin
                // A partial write is simply dropped with the counter
                state_r <= spi_reg_slave_pkg::FR_IDLE;
                bit_cnt_r <= 5'h00;
            end else begin
                unique case (state_r)
                    spi_reg_slave_pkg::FR_IDLE: begin
                        state_r <= spi_reg_slave_pkg::FR_HEADER;
                        bit_cnt_r <= 5'h00;
                    end
                    spi_reg_slave_pkg::FR_HEADER: begin
                        if (sclk_fall) begin
                            hdr_r <= {hdr_r[`SRS_HDR_BITS-2:0], mosi_q_r};
                            if (bit_cnt_r == 5'(`SRS_ADDR_END - 1)) begin
                                addr_r <= {hdr_r[ADDR_W-2:0], mosi_q_r};
                            end
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            if (bit_cnt_r == 5'(`SRS_HDR_BITS - 1)) begin
                                // Direction bit now sits one below the top of the header register
                                if (hdr_r[`SRS_HDR_BITS-2] || chained_r) begin
                                    state_r <= spi_reg_slave_pkg::FR_WRITE;
                                end else begin
                                    state_r <= spi_reg_slave_pkg::FR_READ;
                                end
                            end
                        end
                    end
                    spi_reg_slave_pkg::FR_READ: begin
                        // Input bits here are ignored
                        if (sclk_fall) begin
                            if (bit_cnt_r == last_bit) begin
                                addr_r <= addr_r + 10'h001;
                                bit_cnt_r <= 5'(`SRS_HDR_BITS);
                            end else begin
                                bit_cnt_r <= bit_cnt_r + 5'h01;
                            end
                        end
                    end
                    spi_reg_slave_pkg::FR_WRITE: begin
                        if (sclk_fall) begin
                            if (bit_cnt_r == last_bit) begin
                                bit_cnt_r <= 5'h00;
                                // Chained packets carry full headers again
                                if (chain_more) begin
                                    state_r <= spi_reg_slave_pkg::FR_HEADER;
                                end else begin
                                    state_r <= spi_reg_slave_pkg::FR_READ;
                                    bit_cnt_r <= 5'(`SRS_HDR_BITS);
                                end
                            end else begin
                                bit_cnt_r <= bit_cnt_r + 5'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Chained-packet direction
    // ------------------------------------------------------------
    // Packets chained after a write are writes whatever their first bit says;
    // the header decision ORs this flag in, so a stray zero cannot start a read.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            chained_r <= 1'b0;
        end else if (cs_n_q_r) begin
            chained_r <= 1'b0;
        end else if (push_r && state_r == spi_reg_slave_pkg::FR_HEADER) begin
            chained_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Write packet capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            wdata_r <= 8'h00;
        end else if (state_r == spi_reg_slave_pkg::FR_WRITE && sclk_fall) begin
            wdata_r <= {wdata_r[DATA_W-2:0], mosi_q_r};
        end
    end

    // Commit on the 24th falling edge only; a cut frame never gets here
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            push_r <= 1'b0;
            push_addr_r <= 10'h000;
            push_data_r <= 8'h00;
        end else begin
            push_r <= frame_end_wr;
            if (frame_end_wr) begin
                push_addr_r <= addr_r;
                push_data_r <= {wdata_r[DATA_W-2:0], mosi_q_r};
            end
        end
    end

    // Write packets completed under this select, the first included, held at seven
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            packets_r <= 4'h0;
        end else if (cs_n_q_r) begin
            packets_r <= 4'h0;
        end else if (frame_end_wr && chain_more) begin
            packets_r <= packets_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Read data shifter
    // ------------------------------------------------------------
    // Loaded on the falling edge ending the dead bits, shifted on rising edges
    logic tx_active_r;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 8'h00;
            tx_active_r <= 1'b0;
        end else if (cs_n_q_r) begin
            tx_r <= 8'h00;
            tx_active_r <= 1'b0;
        end else if (state_r == spi_reg_slave_pkg::FR_READ && !chained_r &&
                     sclk_fall && bit_cnt_r == last_bit) begin
            tx_r <= 8'h00;
            tx_active_r <= 1'b0;
        end else if (!tx_active_r && state_r == spi_reg_slave_pkg::FR_READ && !chained_r &&
                     bit_cnt_r == 5'(`SRS_HDR_BITS)) begin
            tx_r <= reg_rd_data_in & USED_MASK;
            tx_active_r <= 1'b1;
        end else if (tx_active_r && sclk_rise && bit_cnt_r != 5'(`SRS_HDR_BITS)) begin
            tx_r <= {tx_r[DATA_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Serial output pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
        end else begin
            miso_oe_out <= !cs_n_q_r;
            // Zero outside data positions of a read
            miso_out <= tx_active_r ? tx_r[DATA_W-1] : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write path through the FIFO
    // ------------------------------------------------------------
    // Only the writable bits are flagged; storage must honour the mask
    logic [ADDR_W+DATA_W-1:0] fifo_out;
    logic overflow_r;
    logic fifo_valid;
    logic fifo_pop;
    logic out_valid_r;
    logic [ADDR_W-1:0] out_addr_r;
    logic [DATA_W-1:0] out_data_r;
    write_fifo #(
        .WIDTH(ADDR_W + DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_write_fifo (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .wr_data_in({push_addr_r, push_data_r & WRITABLE_MASK}),
        .wr_valid_in(push_r),
        .wr_ready_out(fifo_ready),
        .rd_data_out(fifo_out),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // Output stage keeps the write port on flip-flops;
    // capacity becomes FIFO_DEPTH plus one pending write
    assign fifo_pop = fifo_valid && (!out_valid_r || reg_wr_ready_in);
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_r <= 1'b0;
        end else if (fifo_pop) begin
            out_valid_r <= 1'b1;
        end else if (reg_wr_ready_in) begin
            out_valid_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            out_addr_r <= 10'h000;
            out_data_r <= 8'h00;
        end else if (fifo_pop) begin
            out_addr_r <= fifo_out[ADDR_W+DATA_W-1:DATA_W];
            out_data_r <= fifo_out[DATA_W-1:0];
        end
    end
    assign reg_wr_valid_out = out_valid_r;
    assign reg_wr_addr_out = out_addr_r;
    assign reg_wr_data_out = out_data_r;
    assign reg_wr_mask_out = WRITABLE_MASK;

    // The link cannot be stalled, so a full FIFO drops the write and flags it
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            overflow_r <= 1'b0;
        end else if (push_r && !fifo_ready) begin
            overflow_r <= 1'b1;
        end
    end
    assign wr_overflow_out = overflow_r;
endmodule
`default_nettype wire

// file: rtl/write_fifo.sv
// Small FIFO with valid/ready on both sides, holding pending register writes.
// Assumes a single clock and a synchronous active-low reset copy.
`timescale 1ns/1ps
`default_nettype none
module write_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("write_fifo: DEPTH must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wptr_r;
    logic [AW:0] rptr_r;
    logic full;
    logic empty;
    logic push;
    logic pop;
    assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    assign empty = (wptr_r == rptr_r);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign push = wr_valid_in && !full;
    assign pop = rd_ready_in && !empty;
    assign rd_data_out = mem_r[rptr_r[AW-1:0]];
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wptr_r[AW-1:0]] <= wr_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
